// ### hdl/afc_pkg.sv
// Package for the automatic receive flow control block: register map, fields, timing.
// Assumes a 40 MHz system clock and a 16 KB receive data FIFO.
package afc_pkg;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [7:0]  FLOW_CTRL_CONFIG_OFS = 8'hac;  // Flow control configuration register.
	localparam logic [7:0]  FLOW_CTRL_STATUS_OFS = 8'hc0;  // Read-only status of the block.
	localparam logic [31:0] FLOW_CTRL_CONFIG_RST = 32'h0000_0000;  // All fields clear after reset.
	localparam logic [31:0] CONFIG_WRITE_MASK    = 32'h00ff_ffff;  // Bits 31:24 are reserved.

	// ==========================================================================
	// Field positions of the configuration register
	// ==========================================================================
	localparam int HIGH_THR_LSB   = 16;  // Pause high threshold, 64-byte units.
	localparam int LOW_THR_LSB    = 8;   // Resume low threshold, 64-byte units.
	localparam int BP_LEN_LSB     = 4;   // Back-pressure length code.
	localparam int MCAST_EN_BIT   = 3;   // Multicast trigger enable.
	localparam int BCAST_EN_BIT   = 2;   // Broadcast trigger enable.
	localparam int OWNADDR_EN_BIT = 1;   // Own-address trigger enable.
	localparam int ANY_EN_BIT     = 0;   // Any-frame trigger enable.

	// Field positions of the status register.
	localparam int ST_LEVEL_BIT = 0;  // High threshold reached.
	localparam int ST_BELOW_BIT = 1;  // Fill below low threshold.
	localparam int ST_BP_BIT    = 2;  // Back pressure being applied.
	localparam int ST_HELD_BIT  = 3;  // Partner paused, waiting to resume.

	// ==========================================================================
	// Sizes and timing
	// ==========================================================================
	localparam int FILL_W       = 14;  // Byte count width of the receive data FIFO.
	localparam int UNIT_SHIFT   = 6;   // Threshold unit is 64 bytes.
	localparam int BP_CNT_W     = 15;  // Wide enough for the longest back-pressure time.
	localparam int CLK_PERIOD_NS = 25; // System clock period.

	// Back-pressure times in ns, indexed by the length code, for each line rate.
	localparam int BP_NS_100M [16] = '{5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
		250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
	localparam int BP_NS_10M [16] = '{7200, 12200, 17200, 27200, 52200, 102200, 152200, 202200,
		252200, 302200, 352200, 402200, 452200, 502200, 552200, 602200};

	// Pause controller states.
	typedef enum logic [3:0] {
		PS_IDLE   = 4'b0001,  // No pause outstanding.
		PS_PAUSE  = 4'b0010,  // Pause frame requested, waiting for the MAC.
		PS_HELD   = 4'b0100,  // Pause sent, waiting for the fill to drop.
		PS_RESUME = 4'b1000   // Zero-time pause requested, waiting for the MAC.
	} afc_pause_state_t;

	// Back-pressure time in clock cycles; a least time, so it rounds up, then the divider shortens it.
	function automatic logic [BP_CNT_W-1:0] afc_bp_cycles(input logic [3:0] code, input logic fast,
		input int div);
		int ns;
		int cyc;
		ns  = fast ? BP_NS_100M[code] : BP_NS_10M[code];
		cyc = ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) / div;
		if (cyc < 1) begin
			cyc = 1;
		end
		return cyc[BP_CNT_W-1:0];
	endfunction

endpackage

// ### hdl/afc_level_cmp.sv
// Registered comparison of the receive FIFO byte count against a threshold in 64-byte units.
// Assumes the byte count is produced on the same clock.
`timescale 1ns/1ps
module afc_level_cmp import afc_pkg::*; #(
	parameter bit BELOW = 1'b0  // 0: flag fill at or above, 1: flag fill strictly below.
) (
	input  wire logic              ref_clk,     // System clock.
	input  wire logic              rst,         // Asynchronous reset, active high.
	input  wire logic [FILL_W-1:0] fillBytes,   // Current receive FIFO byte count.
	input  wire logic [7:0]        thrUnits,    // Threshold in 64-byte units.
	output logic                   hit          // Registered comparison result.
);

	// Threshold scaled to bytes; 255 units still fit the count width.
	logic [FILL_W-1:0] thrBytes;  // Threshold in bytes.
	assign thrBytes = {thrUnits, {UNIT_SHIFT{1'b0}}};

	// The compare is registered so the long carry chain never reaches the controller directly.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= BELOW ? (fillBytes < thrBytes) : (fillBytes >= thrBytes);
		end
	end

endmodule

// ### hdl/afc_flow_ctrl.sv
// Automatic receive flow control: pause frames in full duplex, back pressure in half duplex.
// Assumes an APB master on the system clock and MAC signals generated on the same clock.
//
// Notes on behaviour
// - No pause or back pressure while transmitter off.
// - High threshold bits 23:16, 64-byte units.
// - Full duplex: one pause at high level.
// - Half duplex: jam matching frames for set length.
// - Low threshold bits 15:8; below it, zero pause.
// - Zero pause only after an earlier high pause.
// - Code bits 7:4 select back-pressure time.
// - Multicast, broadcast, own-address triggers, half duplex.
// - Any-frame bit overrides others, enables pause.
`timescale 1ns/1ps
module afc_flow_ctrl import afc_pkg::*; #(
	parameter int BP_DIV = 1  // Divides back-pressure counts; keep 1 in silicon.
) (
	input  wire logic              ref_clk,        // System clock, 40 MHz.
	input  wire logic              rst,            // Asynchronous reset, active high.
	input  wire logic [7:0]        paddr,          // APB byte address.
	input  wire logic              psel,           // APB select.
	input  wire logic              penable,        // APB access phase.
	input  wire logic              pwrite,         // APB write when high.
	input  wire logic [31:0]       pwdata,         // APB write data.
	output logic      [31:0]       prdata,         // APB read data.
	output logic                   pready,         // APB ready, always high.
	output logic                   pslverr,        // APB error on an unmapped address.
	input  wire logic [FILL_W-1:0] rxFifoBytes,    // Receive data FIFO fill in bytes.
	input  wire logic              txEnabled,      // Transmitter enabled.
	input  wire logic              fullDuplex,     // Link is full duplex.
	input  wire logic              speed100,       // Link runs at 100 Mb/s.
	input  wire logic [15:0]       pauseTimeValue, // Pause time from the MAC flow register.
	input  wire logic              rxPreamble,     // Pulse: valid preamble seen.
	input  wire logic              rxAddrValid,    // Pulse: destination address decoded.
	input  wire logic              rxMulticast,    // Decoded frame is multicast.
	input  wire logic              rxBroadcast,    // Decoded frame is broadcast.
	input  wire logic              rxOwnAddr,      // Decoded frame is for this station.
	input  wire logic              pauseAck,       // Pulse: MAC has taken the pause request.
	output logic                   pauseReq,       // Pause frame request, held until acknowledged.
	output logic      [15:0]       pauseTime,      // Pause time for the requested frame.
	output logic                   backpressure    // Jam the medium while high.
);

	// ==========================================================================
	// Register file
	// ==========================================================================
	logic [31:0]      flowCtrlConfig;  // Configuration register.
	logic             levelReached;    // Fill at or above the high threshold.
	logic             belowLow;        // Fill below the low threshold.
	afc_pause_state_t pauseState;      // Pause controller state.
	afc_pause_state_t next_pauseState; // Next pause controller state.
	logic [BP_CNT_W-1:0] bpCount;      // Remaining back-pressure cycles.
	logic             wrStrobe;        // Write access phase.
	logic             hitCfg;          // Address is the configuration register.
	logic             hitStat;         // Address is the status register.

	assign hitCfg   = (paddr == FLOW_CTRL_CONFIG_OFS);
	assign hitStat  = (paddr == FLOW_CTRL_STATUS_OFS);
	assign wrStrobe = psel & penable & pwrite;
	assign pready   = 1'b1;  // Zero wait states; every access ends at its first access edge.
	assign pslverr  = psel & penable & ~(hitCfg | hitStat);

	// Configuration writes land at the access edge; reserved bits stay zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flowCtrlConfig <= FLOW_CTRL_CONFIG_RST;
		end else if (wrStrobe && hitCfg) begin
			flowCtrlConfig <= pwdata & CONFIG_WRITE_MASK;
		end
	end

	// Read data is combinational from registers; unmapped addresses read zero.
	always_comb begin
		prdata = 32'h0000_0000;
		if (hitCfg) begin
			prdata = flowCtrlConfig;
		end else if (hitStat) begin
			prdata[ST_LEVEL_BIT] = levelReached;
			prdata[ST_BELOW_BIT] = belowLow;
			prdata[ST_BP_BIT]    = backpressure;
			prdata[ST_HELD_BIT]  = (pauseState == PS_HELD);
		end
	end

	// Field views of the configuration.
	logic [7:0] pauseHighThreshold;  // High threshold in 64-byte units.
	logic [7:0] resumeLowThreshold;  // Low threshold in 64-byte units.
	logic [3:0] backpressureLength;  // Back-pressure length code.
	logic       anyFrameTriggerEn;   // Any-frame trigger and full-duplex pause enable.
	logic       matchTrigger;        // Decoded frame matches an enabled class.

	assign pauseHighThreshold = flowCtrlConfig[HIGH_THR_LSB +: 8];
	assign resumeLowThreshold = flowCtrlConfig[LOW_THR_LSB +: 8];
	assign backpressureLength = flowCtrlConfig[BP_LEN_LSB +: 4];
	assign anyFrameTriggerEn  = flowCtrlConfig[ANY_EN_BIT];
	// The any-frame bit takes over, so class matches count only when it is clear.
	assign matchTrigger = ~anyFrameTriggerEn & ((rxMulticast & flowCtrlConfig[MCAST_EN_BIT])
		| (rxBroadcast & flowCtrlConfig[BCAST_EN_BIT]) | (rxOwnAddr & flowCtrlConfig[OWNADDR_EN_BIT]));

	// ==========================================================================
	// Level detection
	// ==========================================================================
	afc_level_cmp #(.BELOW(1'b0)) highCmp (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.fillBytes(rxFifoBytes),
		.thrUnits (pauseHighThreshold),
		.hit      (levelReached)
	);

	afc_level_cmp #(.BELOW(1'b1)) lowCmp (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.fillBytes(rxFifoBytes),
		.thrUnits (resumeLowThreshold),
		.hit      (belowLow)
	);

	// ==========================================================================
	// Full-duplex pause controller
	// ==========================================================================
	// A request waits while the transmitter is off rather than being dropped, so the partner
	// still learns of the congestion once transmission resumes.
	always_comb begin
		next_pauseState = pauseState;
		unique case (pauseState)
			PS_IDLE: begin
				if (fullDuplex && anyFrameTriggerEn && levelReached) begin
					next_pauseState = PS_PAUSE;
				end
			end
			PS_PAUSE: begin
				if (pauseAck && txEnabled) begin
					next_pauseState = PS_HELD;
				end
			end
			PS_HELD: begin
				if (anyFrameTriggerEn && belowLow) begin
					next_pauseState = PS_RESUME;
				end
			end
			PS_RESUME: begin
				if (pauseAck && txEnabled) begin
					next_pauseState = PS_IDLE;
				end
			end
			default: begin
				next_pauseState = PS_IDLE;  // Recover from an illegal code.
			end
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pauseState <= PS_IDLE;
		end else begin
			pauseState <= next_pauseState;
		end
	end

	// Pause time is latched on entering a sending state, so it stays stable under the request.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pauseTime <= 16'h0000;
		end else if (pauseState == PS_IDLE && next_pauseState == PS_PAUSE) begin
			pauseTime <= pauseTimeValue;
		end else if (pauseState == PS_HELD && next_pauseState == PS_RESUME) begin
			pauseTime <= 16'h0000;
		end
	end

	assign pauseReq = txEnabled & ((pauseState == PS_PAUSE) | (pauseState == PS_RESUME));

	// ==========================================================================
	// Half-duplex back pressure
	// ==========================================================================
	logic bpStart;  // Start jamming from the next cycle.
	assign bpStart = txEnabled & ~fullDuplex & levelReached
		& ((anyFrameTriggerEn & rxPreamble) | (rxAddrValid & matchTrigger));

	// Each trigger reloads the full length; a disabled transmitter cancels the jam at once.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bpCount <= '0;
		end else if (!txEnabled || fullDuplex) begin
			bpCount <= '0;
		end else if (bpStart) begin
			bpCount <= afc_bp_cycles(backpressureLength, speed100, BP_DIV);
		end else if (bpCount != '0) begin
			bpCount <= bpCount - 1'b1;
		end
	end

	assign backpressure = (bpCount != '0) & txEnabled;

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_txoff_quiet: assert property (!txEnabled |-> !pauseReq && !backpressure)
		else $error("Flow control active with transmitter off.");
	// The compare flops are held in reset one edge longer than the check, so skip that edge.
	a_high_compare: assert property (!$past(rst)
		|-> levelReached == ($past(rxFifoBytes) >= {$past(pauseHighThreshold), 6'b0}))
		else $error("High threshold compare wrong.");
	a_low_compare: assert property (!$past(rst)
		|-> belowLow == ($past(rxFifoBytes) < {$past(resumeLowThreshold), 6'b0}))
		else $error("Low threshold compare wrong.");
	a_pause_once: assert property ((pauseState == PS_PAUSE) && pauseAck && txEnabled
		|=> (pauseState == PS_HELD) && !pauseReq)
		else $error("Pause frame not single.");
	a_pause_value: assert property ($rose(pauseState == PS_PAUSE) |-> pauseTime == $past(pauseTimeValue))
		else $error("Pause time not taken from MAC.");
	a_resume_zero: assert property ((pauseState == PS_RESUME) |-> pauseTime == 16'h0000)
		else $error("Resume pause time not zero.");
	a_resume_after: assert property ($rose(pauseState == PS_RESUME) |-> $past(pauseState) == PS_HELD)
		else $error("Resume without earlier pause.");
	a_bp_length: assert property (bpStart |=> bpCount == afc_bp_cycles($past(backpressureLength), $past(speed100), BP_DIV))
		else $error("Back-pressure length wrong.");
	a_bp_trigger: assert property ($rose(backpressure) && txEnabled && $past(txEnabled)
		|-> $past(bpStart) && !$past(fullDuplex))
		else $error("Back pressure without trigger.");
	// A decoded frame of no enabled class, or any frame while the any-frame bit rules, must not reload.
	a_class_gate: assert property (rxAddrValid && !rxPreamble && !fullDuplex && txEnabled && levelReached
		&& (anyFrameTriggerEn || !((rxMulticast & flowCtrlConfig[MCAST_EN_BIT])
		| (rxBroadcast & flowCtrlConfig[BCAST_EN_BIT]) | (rxOwnAddr & flowCtrlConfig[OWNADDR_EN_BIT])))
		|=> bpCount == (($past(bpCount) == '0) ? '0 : $past(bpCount) - 1'b1))
		else $error("Class trigger not gated.");
	// A transmitter switched off in the next cycle must silence the jam, so that case is excused.
	a_any_trigger: assert property (rxPreamble && anyFrameTriggerEn && levelReached && txEnabled && !fullDuplex
		|=> backpressure || !txEnabled)
		else $error("Any-frame trigger missed.");

	c_pause_sent: cover property ((pauseState == PS_PAUSE) && pauseAck && txEnabled);
	c_resume_sent: cover property ((pauseState == PS_RESUME) && pauseAck && txEnabled);
	c_bp_done: cover property ($fell(backpressure) && txEnabled);

endmodule

// ### verif/afc_link_partner.sv
// Model of the far side: the link partner's frames and the MAC that takes pause requests.
// Assumes the flow control block runs on the same clock.
`timescale 1ns/1ps
module afc_link_partner (
	input  wire logic       ref_clk,     // System clock.
	input  wire logic [3:0] ackDelay,    // Cycles a pause request waits before it is taken.
	input  wire logic       pauseReq,    // Pause request from the block.
	output logic            pauseAck,    // Pulse: pause request taken.
	output logic            rxPreamble,  // Pulse: valid preamble seen.
	output logic            rxAddrValid, // Pulse: address decoded.
	output logic [2:0]      rxClass      // Multicast, broadcast, own address.
);
	// ==========
	// Pause acknowledge
	// ==========
	logic [3:0] waitCnt; // Cycles the current request has waited.

	initial begin
		pauseAck    = 1'b0;
		rxPreamble  = 1'b0;
		rxAddrValid = 1'b0;
		rxClass     = 3'b000;
		waitCnt     = 4'h0;
	end

	// A busy MAC may sit on a request; the delay lets the bench test prompt and slow answers.
	always @(posedge ref_clk) begin
		pauseAck <= pauseReq && !pauseAck && waitCnt >= ackDelay;
		waitCnt  <= (pauseReq && !pauseAck && waitCnt < ackDelay) ? waitCnt + 4'h1 : 4'h0;
	end

	// ==========
	// Frame start
	// ==========
	// Sends a preamble, then the decoded address class a few cycles later.
	task automatic send_frame(input logic [2:0] cls);
		@(posedge ref_clk);
		rxPreamble <= 1'b1;
		@(posedge ref_clk);
		rxPreamble <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rxAddrValid <= 1'b1;
		rxClass     <= cls;
		@(posedge ref_clk);
		rxAddrValid <= 1'b0;
		// Class lines are not valid outside the decode pulse, so they must not look steady.
		rxClass     <= ~cls;
	endtask
endmodule

// ### verif/afc_flow_ctrl_tb.sv
// Self-checking bench for the flow control block: registers, pause frames, back pressure.
// Assumes the link partner model drives the receive side and acknowledges pauses.
`timescale 1ns/1ps
module afc_flow_ctrl_tb import afc_pkg::*; ();
	localparam int DIV = 100; // Shortens back-pressure counts for simulation.

	logic              ref_clk;        // System clock.
	logic              rst;            // Reset, active high.
	logic [7:0]        paddr;          // APB address.
	logic              psel;           // APB select.
	logic              penable;        // APB access phase.
	logic              pwrite;         // APB direction.
	logic [31:0]       pwdata;         // APB write data.
	logic [31:0]       prdata;         // APB read data.
	logic              pready;         // APB ready.
	logic              pslverr;        // APB error.
	logic [FILL_W-1:0] rxFifoBytes;    // FIFO fill.
	logic              txEnabled;      // Transmitter on.
	logic              fullDuplex;     // Duplex mode.
	logic              speed100;       // Line rate.
	logic [15:0]       pauseTimeValue; // Programmed pause time.
	logic              rxPreamble;     // From partner.
	logic              rxAddrValid;    // From partner.
	logic [2:0]        rxClass;        // From partner.
	logic              pauseAck;       // From partner.
	logic              pauseReq;       // Pause request.
	logic [15:0]       pauseTime;      // Pause time.
	logic              backpressure;   // Jam output.
	logic [3:0]        ackDelay;       // Partner answer delay.
	logic [31:0]       rdata;          // Read result.
	logic              rerr;           // Read error.
	int                n;              // Measured count.
	int                n_errors;       // Mismatches.
	int                checked;        // Comparisons.

	afc_flow_ctrl #(.BP_DIV(DIV)) afc_flow_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxFifoBytes(rxFifoBytes), .txEnabled(txEnabled), .fullDuplex(fullDuplex),
		.speed100(speed100), .pauseTimeValue(pauseTimeValue), .rxPreamble(rxPreamble),
		.rxAddrValid(rxAddrValid), .rxMulticast(rxClass[2]), .rxBroadcast(rxClass[1]),
		.rxOwnAddr(rxClass[0]), .pauseAck(pauseAck), .pauseReq(pauseReq), .pauseTime(pauseTime),
		.backpressure(backpressure));
	afc_link_partner afc_link_partner_inst (.ref_clk(ref_clk), .ackDelay(ackDelay), .pauseReq(pauseReq),
		.pauseAck(pauseAck), .rxPreamble(rxPreamble), .rxAddrValid(rxAddrValid), .rxClass(rxClass));

	// ==========
	// Helpers
	// ==========
	always #12.5 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rdata   = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts cycles in which the pause request is up.
	task automatic watch(input int cyc, output int hits);
		hits = 0;
		repeat (cyc) begin
			@(posedge ref_clk);
			hits += (pauseReq !== 1'b0);
		end
	endtask

	// Waits for a pause request, checks its time, then lets the partner take it.
	task automatic pause_seen(input logic [15:0] t);
		for (int i = 0; i < 30 && pauseReq !== 1'b1; i++) @(posedge ref_clk);
		chk(pauseReq, 1, "pause request");
		chk(pauseTime, t, "pause time");
		for (int i = 0; i < 30 && pauseReq === 1'b1; i++) @(posedge ref_clk);
	endtask

	// Sends a frame and measures how long back pressure stays up.
	task automatic bp_len(input logic [2:0] cls, output int len);
		len = 0;
		fork
			afc_link_partner_inst.send_frame(cls);
			begin
				for (int i = 0; i < 12 && backpressure !== 1'b1; i++) @(posedge ref_clk);
				while (backpressure === 1'b1 && len < 400) begin
					len++;
					@(posedge ref_clk);
				end
			end
		join
	endtask

	function automatic int exp_n(input logic [3:0] code, input logic fast);
		int ns;
		ns    = fast ? BP_NS_100M[code] : BP_NS_10M[code];
		exp_n = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS / DIV;
		if (exp_n < 1) begin
			exp_n = 1;
		end
	endfunction

	task automatic print_verdict;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========
	// Tests
	// ==========
	// Trigger table for half duplex: config low byte, frame class, line rate, should it jam.
	logic [7:0] cfgLo [7] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'hF8, 8'h01, 8'h06};
	logic [2:0] cls   [7] = '{3'b100, 3'b010, 3'b001, 3'b000, 3'b100, 3'b000, 3'b100};
	logic       fast  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	logic       jam   [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

	initial begin
		{ref_clk, psel, penable, pwrite, paddr, pwdata, n_errors, checked} = '0;
		{rxFifoBytes, txEnabled, fullDuplex, speed100} = '0;
		pauseTimeValue = 16'h1234;
		ackDelay = 4'h5;
		rst = 1'b1;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		apb(FLOW_CTRL_CONFIG_OFS, 1'b0, 32'h0);
		chk(rdata, FLOW_CTRL_CONFIG_RST, "config reset");
		apb(FLOW_CTRL_CONFIG_OFS, 1'b1, 32'hFFFF_FFFF);
		apb(FLOW_CTRL_CONFIG_OFS, 1'b0, 32'h0);
		chk(rdata, 32'h00FF_FFFF, "reserved bits");
		apb(8'h04, 1'b0, 32'h0);
		chk({rdata[30:0], rerr}, 32'h0000_0001, "unmapped");
		// Full duplex: high 4 units, low 2 units, any-frame enable.
		@(posedge ref_clk);
		fullDuplex <= 1'b1;
		txEnabled  <= 1'b1;
		apb(FLOW_CTRL_CONFIG_OFS, 1'b1, 32'h0004_0201);
		watch(20, n);
		chk(n, 0, "resume without pause");
		rxFifoBytes <= 14'd255;
		watch(20, n);
		chk(n, 0, "below high");
		txEnabled   <= 1'b0;
		rxFifoBytes <= 14'd256;
		watch(20, n);
		chk(n, 0, "tx disabled");
		txEnabled <= 1'b1;
		pause_seen(16'h1234);
		// Held state: level reached, not below low, no jam in full duplex, no bus error.
		apb(FLOW_CTRL_STATUS_OFS, 1'b0, 32'h0);
		chk({rdata[30:0], rerr}, 32'h0000_0012, "status held");
		watch(40, n);
		chk(n, 0, "single pause");
		ackDelay    <= 4'h0;
		rxFifoBytes <= 14'd127;
		pause_seen(16'h0000);
		watch(30, n);
		chk(n, 0, "single resume");
		// Half duplex back pressure at the high level.
		fullDuplex  <= 1'b0;
		rxFifoBytes <= 14'd256;
		for (int k = 0; k < 7; k++) begin
			speed100 <= fast[k];
			apb(FLOW_CTRL_CONFIG_OFS, 1'b1, {16'h0004, 8'h02, cfgLo[k]});
			bp_len(cls[k], n);
			chk(n, jam[k] ? exp_n(cfgLo[k][7:4], fast[k]) : 0, "jam length");
		end
		// Enable the multicast class again so the next two checks could really trip.
		apb(FLOW_CTRL_CONFIG_OFS, 1'b1, 32'h0004_0208);
		txEnabled <= 1'b0;
		bp_len(3'b100, n);
		chk(n, 0, "jam with tx off");
		rxFifoBytes <= 14'd255;
		txEnabled   <= 1'b1;
		repeat (3) @(posedge ref_clk);
		bp_len(3'b100, n);
		chk(n, 0, "jam below high");
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		print_verdict;
	end
endmodule
